// *** board_pin_model.sv ***
// board_pin_model: board wiring seen by the pads of the pin-function block
// assumes pads packed as {pin17, pin14, pins 22..20, pins 57..55}
`timescale 1ns/10ps
`default_nettype none
module board_pin_model (
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] boardLevel,
   output logic [7:0] padIn
);
   // driven pad shows its own level, released pad the board level
   // open-drain pads rest on board pull-up
   assign padIn = (padOe & padOut) | (~padOe & boardLevel);
endmodule : board_pin_model
`default_nettype wire

// *** gpio_pin_cell.sv ***
// gpio_pin_cell: one pin's general-i/o versus peripheral selection
// assumes the pad combines out and enable; level taken as synchronous
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_cell (
   input wire logic takeover,
   input wire logic periphDrive,
   input wire logic periphOe,
   input wire logic dirBit,
   input wire logic dataBit,
   output logic padOut,
   output logic padOe
);
   // ----------------------------------------
   // selection
   // ----------------------------------------
   assign padOut = takeover ? periphDrive : dataBit;
   assign padOe = takeover ? periphOe : dirBit;
endmodule : gpio_pin_cell
`default_nettype wire

// *** open_drain_cell.sv ***
// open_drain_cell: i2c-shared pin, open-drain when the bus interface owns it
// assumes an external pull-up on the wire
`timescale 1ns/10ps
`default_nettype none
module open_drain_cell (
   input wire logic i2cOwn,
   input wire logic i2cPullLow,
   input wire logic dirBit,
   input wire logic dataBit,
   output logic padOut,
   output logic padOe
);
   // ----------------------------------------
   // selection
   // ----------------------------------------
   assign padOut = i2cOwn ? 1'b0 : dataBit;
   assign padOe = i2cOwn ? i2cPullLow : dirBit;
endmodule : open_drain_cell
`default_nettype wire

// *** port_mux_pkg.sv ***
// port_mux_pkg: register map, field positions and reset values of the pin-function block
// assumes a 32-bit avalon-mm slave with word-aligned registers
package port_mux_pkg;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [4:0] OFS_P1_FUNC = 5'h00;
   localparam logic [4:0] OFS_P1_DIR = 5'h04;
   localparam logic [4:0] OFS_P2_DIR = 5'h08;
   localparam logic [4:0] OFS_P2_DATA = 5'h0C;
   localparam logic [4:0] OFS_P5_FUNC = 5'h10;
   localparam logic [4:0] OFS_P5_DIR = 5'h14;
   localparam logic [4:0] OFS_P5_DATA = 5'h18;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_P1_INT3_SEL = 7;
   localparam int BIT_P1_INT0_SEL = 4;
   localparam int BIT_P1_TX = 1;
   localparam int BIT_P1_PIN17 = 7;
   localparam int BIT_P1_PIN14 = 4;
   localparam int BIT_P5_WAKE = 5;

   // ----------------------------------------
   // implemented bit masks and reserved fill
   // ----------------------------------------
   localparam logic [7:0] MASK_P1_FUNC = 8'h92;
   localparam logic [7:0] MASK_P1_DIR = 8'h90;
   localparam logic [7:0] MASK_P2 = 8'h07;
   localparam logic [7:0] MASK_P5_FUNC = 8'h20;
   localparam logic [7:0] MASK_P5 = 8'hE0;
   localparam logic [7:0] RESET_REG = 8'h00;
   localparam logic [7:0] FILL_P2_DATA = 8'hF8;
   localparam logic [7:0] FILL_P5_DATA = 8'h1F;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // ----------------------------------------
   // bus answer sequencer
   // ----------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DONE = 2'b10
   } bus_state_t;

endpackage : port_mux_pkg

// *** port_mux_props.sv ***
// port_mux_props: port-level checks of the pin-function block
// assumes bind into port_pin_function_mux, single clock domain
`timescale 1ns/10ps
`default_nettype none
module port_mux_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic avsWaitrequest,
   input wire logic serialClockOut,
   input wire logic rx_enable_bit,
   input wire logic clock_source_hi_bit,
   input wire logic clock_source_lo_bit,
   input wire logic serialSyncMode,
   input wire logic i2c_enable_bit,
   input wire logic i2cSclPullLow,
   input wire logic i2cSdaPullLow,
   input wire logic pin17In,
   input wire logic pin17Oe,
   input wire logic ext_interrupt_three,
   input wire logic pin14In,
   input wire logic pin14Oe,
   input wire logic ext_interrupt_zero,
   input wire logic [2:0] port2In,
   input wire logic [2:0] port2Out,
   input wire logic [2:0] port2Oe,
   input wire logic serialRxData,
   input wire logic [2:0] port5In,
   input wire logic [2:0] port5Out,
   input wire logic [2:0] port5Oe,
   input wire logic wakeup_input_five
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take; (avsRead || avsWrite) && avsWaitrequest; endsequence
   sequence s_done; (avsRead || avsWrite) && !avsWaitrequest; endsequence
   property p_answer; s_take |=> s_done; endproperty
   a_answer: assert property (p_answer) else $error("no answer after one wait state");
   property p_int3; !ext_interrupt_three |-> !pin17In && !pin17Oe; endproperty
   a_int3: assert property (p_int3) else $error("pin17 owned but driven");
   property p_int0; !ext_interrupt_zero |-> !pin14In && !pin14Oe; endproperty
   a_int0: assert property (p_int0) else $error("pin14 owned but driven");
   property p_rx; rx_enable_bit |-> !port2Oe[1] && serialRxData == port2In[1]; endproperty
   a_rx: assert property (p_rx) else $error("pin21 not receive input");
   property p_clkOut; !clock_source_hi_bit && (serialSyncMode || clock_source_lo_bit)
      |-> port2Oe[0] && port2Out[0] == serialClockOut; endproperty
   a_clkOut: assert property (p_clkOut) else $error("pin20 not clock output");
   property p_scl; i2c_enable_bit |-> !port5Out[2] && port5Oe[2] == i2cSclPullLow; endproperty
   a_scl: assert property (p_scl) else $error("pin57 not open drain");
   property p_sda; i2c_enable_bit |-> !port5Out[1] && port5Oe[1] == i2cSdaPullLow; endproperty
   a_sda: assert property (p_sda) else $error("pin56 not open drain");
   property p_wake; !wakeup_input_five |-> !port5In[0] && !port5Oe[0]; endproperty
   a_wake: assert property (p_wake) else $error("pin55 owned but driven");
endmodule : port_mux_props
bind port_pin_function_mux port_mux_props u_props (.clk(clk), .rst_n(rst_n), .avsRead(avsRead),
   .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest), .serialClockOut(serialClockOut),
   .rx_enable_bit(rx_enable_bit), .clock_source_hi_bit(clock_source_hi_bit),
   .clock_source_lo_bit(clock_source_lo_bit), .serialSyncMode(serialSyncMode),
   .i2c_enable_bit(i2c_enable_bit), .i2cSclPullLow(i2cSclPullLow), .i2cSdaPullLow(i2cSdaPullLow),
   .pin17In(pin17In), .pin17Oe(pin17Oe), .ext_interrupt_three(ext_interrupt_three),
   .pin14In(pin14In), .pin14Oe(pin14Oe), .ext_interrupt_zero(ext_interrupt_zero),
   .port2In(port2In), .port2Out(port2Out), .port2Oe(port2Oe), .serialRxData(serialRxData),
   .port5In(port5In), .port5Out(port5Out), .port5Oe(port5Oe), .wakeup_input_five(wakeup_input_five));
`default_nettype wire

// *** port_pin_function_mux.sv ***
// port_pin_function_mux: general i/o for port 2 and port 5, function select for pins 17 and 14
// assumes avalon-mm master on clk; pin inputs synchronous to clk
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// (RULE1) pin17: select bit picks interrupt/trigger over gpio
// (RULE2) pin14: select bit picks interrupt input over gpio
// (RULE3) port1 mode and serial settings beat gpio
// (RULE4) port2 direction: 1 output, 0 input
// (RULE5) port2 read: latch if output, pin otherwise
// (RULE6) pin22 becomes transmit when select set
// (RULE7) pin21 becomes receive when receiver enabled
// (RULE8) pin20 serial clock per clock-enable and mode bits
// (RULE9) i2c setting beats gpio on port5 pins 57 and 56
// (RULE10) port5 bit5 selects wakeup/converter trigger input
// (RULE11) port5 direction bits 7..5: 1 output
// (RULE12) port5 read: latch or pin; reserved read one
// (RULE13) pin57 open-drain i2c clock when enabled
// (RULE14) pin56 open-drain i2c data when enabled
// (RULE15) reserved writes ignored; direction reads harmless
module port_pin_function_mux (
   input wire logic clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [4:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0] avsByteenable,
   output logic [31:0] avsReaddata,
   output logic avsWaitrequest,
   // peripheral settings
   input wire logic serialTxData,
   input wire logic rx_enable_bit,
   input wire logic clock_source_hi_bit,
   input wire logic clock_source_lo_bit,
   input wire logic serialSyncMode,
   input wire logic serialClockOut,
   input wire logic i2c_enable_bit,
   input wire logic i2cSclPullLow,
   input wire logic i2cSdaPullLow,
   // pins 17 and 14
   input wire logic pin17In,
   output logic pin17Out,
   output logic pin17Oe,
   input wire logic pin14In,
   output logic pin14Out,
   output logic pin14Oe,
   // port 2 pins 22..20
   input wire logic [2:0] port2In,
   output logic [2:0] port2Out,
   output logic [2:0] port2Oe,
   // port 5 pins 57..55
   input wire logic [2:0] port5In,
   output logic [2:0] port5Out,
   output logic [2:0] port5Oe,
   // peripheral inputs taken from the pins
   output logic ext_interrupt_three,
   output logic timer_trigger_input,
   output logic ext_interrupt_zero,
   output logic serialRxData,
   output logic serialClockIn,
   output logic wakeup_input_five,
   output logic converter_trigger_input,
   output logic i2cSclIn,
   output logic i2cSdaIn
);
   import port_mux_pkg::*;

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // read-back: latch where output, live pin where input
   function automatic logic [7:0] mix_read(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pin, input logic [7:0] mask,
                                           input logic [7:0] fill);
      mix_read = (((dir & lat) | (~dir & pin)) & mask) | fill;
   endfunction : mix_read

   // byte-lane merge keeping only implemented bits
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr,
                                        input logic [7:0] mask);
      merge = (old & ~mask) | (wr & mask);
   endfunction : merge

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] port1_function_reg_q;
   logic [7:0] port1_direction_reg_q;
   logic [7:0] port2_direction_reg_q;
   logic [7:0] port2_data_reg_q;
   logic [7:0] port5_function_reg_q;
   logic [7:0] port5_direction_reg_q;
   logic [7:0] port5_data_reg_q;
   logic [31:0] readData_q;
   bus_state_t busState_q;
   bus_state_t busState_d;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire logic busReq = avsRead | avsWrite;
   wire logic accept = busReq && (busState_q == BUS_IDLE);
   wire logic complete = busReq && (busState_q == BUS_DONE);
   wire logic wrStb = complete && avsWrite && avsByteenable[0];
   wire logic [7:0] wrByte = avsWritedata[7:0];
   wire logic hitP1Func = (avsAddress == OFS_P1_FUNC);
   wire logic hitP1Dir = (avsAddress == OFS_P1_DIR);
   wire logic hitP2Dir = (avsAddress == OFS_P2_DIR);
   wire logic hitP2Data = (avsAddress == OFS_P2_DATA);
   wire logic hitP5Func = (avsAddress == OFS_P5_FUNC);
   wire logic hitP5Dir = (avsAddress == OFS_P5_DIR);
   wire logic hitP5Data = (avsAddress == OFS_P5_DATA);

   // ----------------------------------------
   // pin function decisions
   // ----------------------------------------
   // (RULE3) peripheral selects decided first
   wire logic sel17 = port1_function_reg_q[BIT_P1_INT3_SEL];
   wire logic sel14 = port1_function_reg_q[BIT_P1_INT0_SEL];
   wire logic sel22 = port1_function_reg_q[BIT_P1_TX];
   wire logic sel21 = rx_enable_bit;
   // (RULE8) clock pin owner and direction
   wire logic clkIn20 = clock_source_hi_bit;
   wire logic clkOut20 = !clock_source_hi_bit && (serialSyncMode || clock_source_lo_bit);
   wire logic sel20 = clkIn20 || clkOut20;
   // (RULE9) i2c owns pins 57 and 56
   wire logic selI2c = i2c_enable_bit;
   wire logic sel55 = port5_function_reg_q[BIT_P5_WAKE];

   wire logic [7:0] port2PinByte = {5'h00, port2In};
   wire logic [7:0] port5PinByte = {port5In, 5'h00};
   wire logic [7:0] port2Read = mix_read(port2_direction_reg_q, port2_data_reg_q, port2PinByte,
                                         MASK_P2, FILL_P2_DATA);
   wire logic [7:0] port5Read = mix_read(port5_direction_reg_q, port5_data_reg_q, port5PinByte,
                                         MASK_P5, FILL_P5_DATA);

   // (RULE15) direction registers read as zero, no side effect
   wire logic [7:0] readByte =
      hitP1Func ? (port1_function_reg_q & MASK_P1_FUNC) :
      hitP2Data ? port2Read :
      hitP5Func ? (port5_function_reg_q & MASK_P5_FUNC) :
      hitP5Data ? port5Read : 8'h00;
   wire logic mapped = hitP1Func | hitP1Dir | hitP2Dir | hitP2Data | hitP5Func | hitP5Dir | hitP5Data;
   wire logic [31:0] readWord = mapped ? {24'h00_0000, readByte} : READ_UNMAPPED;

   // ----------------------------------------
   // bus answer: one wait cycle, answer on second edge
   // ----------------------------------------
   always_comb begin
      busState_d = busState_q;
      case (busState_q)
         BUS_IDLE: begin
            if (busReq) begin
               busState_d = BUS_DONE;
            end
         end
         BUS_DONE: begin
            busState_d = BUS_IDLE;
         end
         default: begin
            busState_d = BUS_IDLE;
         end
      endcase
   end

   assign avsWaitrequest = busReq && (busState_q != BUS_DONE);
   assign avsReaddata = readData_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busState_q <= BUS_IDLE;
      end else begin
         busState_q <= busState_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readData_q <= 32'h0000_0000;
      end else if (accept && avsRead) begin
         readData_q <= readWord;
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // (RULE15) reserved bits masked on write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port1_function_reg_q <= RESET_REG;
         port1_direction_reg_q <= RESET_REG;
      end else begin
         if (wrStb && hitP1Func) begin
            port1_function_reg_q <= merge(port1_function_reg_q, wrByte, MASK_P1_FUNC);
         end
         if (wrStb && hitP1Dir) begin
            port1_direction_reg_q <= merge(port1_direction_reg_q, wrByte, MASK_P1_DIR);
         end
      end
   end

   // (RULE4) port2 direction and data latches
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port2_direction_reg_q <= RESET_REG;
         port2_data_reg_q <= RESET_REG;
      end else begin
         if (wrStb && hitP2Dir) begin
            port2_direction_reg_q <= merge(port2_direction_reg_q, wrByte, MASK_P2);
         end
         // (RULE5) data latch holds output values
         if (wrStb && hitP2Data) begin
            port2_data_reg_q <= merge(port2_data_reg_q, wrByte, MASK_P2);
         end
      end
   end

   // (RULE10) function select bit 5 only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port5_function_reg_q <= RESET_REG;
         port5_direction_reg_q <= RESET_REG;
         port5_data_reg_q <= RESET_REG;
      end else begin
         if (wrStb && hitP5Func) begin
            port5_function_reg_q <= merge(port5_function_reg_q, wrByte, MASK_P5_FUNC);
         end
         // (RULE11) port5 direction bits 7..5
         if (wrStb && hitP5Dir) begin
            port5_direction_reg_q <= merge(port5_direction_reg_q, wrByte, MASK_P5);
         end
         // (RULE12) port5 data latch
         if (wrStb && hitP5Data) begin
            port5_data_reg_q <= merge(port5_data_reg_q, wrByte, MASK_P5);
         end
      end
   end

   // ----------------------------------------
   // pin cells
   // ----------------------------------------
   // (RULE1) pin17 input-only when selected
   gpio_pin_cell u_pin17 (
      .takeover(sel17),
      .periphDrive(1'b0),
      .periphOe(1'b0),
      .dirBit(port1_direction_reg_q[BIT_P1_PIN17]),
      .dataBit(1'b0),
      .padOut(pin17Out),
      .padOe(pin17Oe)
   );

   // (RULE2) pin14 input-only when selected
   gpio_pin_cell u_pin14 (
      .takeover(sel14),
      .periphDrive(1'b0),
      .periphOe(1'b0),
      .dirBit(port1_direction_reg_q[BIT_P1_PIN14]),
      .dataBit(1'b0),
      .padOut(pin14Out),
      .padOe(pin14Oe)
   );

   // (RULE6) pin22 serial transmit
   gpio_pin_cell u_pin22 (
      .takeover(sel22),
      .periphDrive(serialTxData),
      .periphOe(1'b1),
      .dirBit(port2_direction_reg_q[2]),
      .dataBit(port2_data_reg_q[2]),
      .padOut(port2Out[2]),
      .padOe(port2Oe[2])
   );

   // (RULE7) pin21 serial receive
   gpio_pin_cell u_pin21 (
      .takeover(sel21),
      .periphDrive(1'b0),
      .periphOe(1'b0),
      .dirBit(port2_direction_reg_q[1]),
      .dataBit(port2_data_reg_q[1]),
      .padOut(port2Out[1]),
      .padOe(port2Oe[1])
   );

   // (RULE8) pin20 serial clock in or out
   gpio_pin_cell u_pin20 (
      .takeover(sel20),
      .periphDrive(serialClockOut),
      .periphOe(clkOut20),
      .dirBit(port2_direction_reg_q[0]),
      .dataBit(port2_data_reg_q[0]),
      .padOut(port2Out[0]),
      .padOe(port2Oe[0])
   );

   // (RULE13) pin57 open-drain i2c clock
   open_drain_cell u_pin57 (
      .i2cOwn(selI2c),
      .i2cPullLow(i2cSclPullLow),
      .dirBit(port5_direction_reg_q[7]),
      .dataBit(port5_data_reg_q[7]),
      .padOut(port5Out[2]),
      .padOe(port5Oe[2])
   );

   // (RULE14) pin56 open-drain i2c data
   open_drain_cell u_pin56 (
      .i2cOwn(selI2c),
      .i2cPullLow(i2cSdaPullLow),
      .dirBit(port5_direction_reg_q[6]),
      .dataBit(port5_data_reg_q[6]),
      .padOut(port5Out[1]),
      .padOe(port5Oe[1])
   );

   // (RULE10) pin55 wakeup / converter trigger input
   gpio_pin_cell u_pin55 (
      .takeover(sel55),
      .periphDrive(1'b0),
      .periphOe(1'b0),
      .dirBit(port5_direction_reg_q[5]),
      .dataBit(port5_data_reg_q[5]),
      .padOut(port5Out[0]),
      .padOe(port5Oe[0])
   );

   // ----------------------------------------
   // peripheral inputs, idle high when not owned; serialClockIn idles low
   // ----------------------------------------
   assign ext_interrupt_three = sel17 ? pin17In : 1'b1;
   assign timer_trigger_input = sel17 ? pin17In : 1'b1;
   assign ext_interrupt_zero = sel14 ? pin14In : 1'b1;
   assign serialRxData = sel21 ? port2In[1] : 1'b1;
   assign serialClockIn = clkIn20 ? port2In[0] : 1'b0;
   assign wakeup_input_five = sel55 ? port5In[0] : 1'b1;
   assign converter_trigger_input = sel55 ? port5In[0] : 1'b1;
   assign i2cSclIn = selI2c ? port5In[2] : 1'b1;
   assign i2cSdaIn = selI2c ? port5In[1] : 1'b1;

endmodule : port_pin_function_mux
`default_nettype wire

// *** testbench.sv ***
// testbench: register and pin scenarios for port_pin_function_mux
// assumes avalon-mm master tasks and board_pin_model on the pads
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import port_mux_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, avsWaitrequest;
   logic [4:0] avsAddress = 5'h00;
   logic [31:0] avsWritedata = 32'h0, avsReaddata, rdv;
   logic [3:0] avsByteenable = 4'h0;
   logic serialTxData = 1'b0, rx_enable_bit = 1'b0, clock_source_hi_bit = 1'b0, clock_source_lo_bit = 1'b0;
   logic serialSyncMode = 1'b0, serialClockOut = 1'b0, i2c_enable_bit = 1'b0;
   logic i2cSclPullLow = 1'b0, i2cSdaPullLow = 1'b0;
   logic ext_interrupt_three, timer_trigger_input, ext_interrupt_zero, serialRxData, serialClockIn;
   logic wakeup_input_five, converter_trigger_input, i2cSclIn, i2cSdaIn;
   logic [7:0] board = 8'h12;
   wire [7:0] padsOut, padsOe, padsIn;
   int fail_count = 0;
   int tests_run = 0;
   always #4 clk = ~clk;
   port_pin_function_mux dut (.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
      .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .serialTxData(serialTxData),
      .rx_enable_bit(rx_enable_bit), .clock_source_hi_bit(clock_source_hi_bit),
      .clock_source_lo_bit(clock_source_lo_bit), .serialSyncMode(serialSyncMode),
      .serialClockOut(serialClockOut), .i2c_enable_bit(i2c_enable_bit), .i2cSclPullLow(i2cSclPullLow),
      .i2cSdaPullLow(i2cSdaPullLow), .ext_interrupt_three(ext_interrupt_three),
      .timer_trigger_input(timer_trigger_input), .ext_interrupt_zero(ext_interrupt_zero),
      .serialRxData(serialRxData), .serialClockIn(serialClockIn), .wakeup_input_five(wakeup_input_five),
      .converter_trigger_input(converter_trigger_input), .i2cSclIn(i2cSclIn), .i2cSdaIn(i2cSdaIn),
      .pin17In(padsIn[7]), .pin17Out(padsOut[7]), .pin17Oe(padsOe[7]),
      .pin14In(padsIn[6]), .pin14Out(padsOut[6]), .pin14Oe(padsOe[6]),
      .port2In(padsIn[5:3]), .port2Out(padsOut[5:3]), .port2Oe(padsOe[5:3]),
      .port5In(padsIn[2:0]), .port5Out(padsOut[2:0]), .port5Oe(padsOe[2:0]));
   board_pin_model u_board (.padOut(padsOut), .padOe(padsOe), .boardLevel(board), .padIn(padsIn));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] v, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= w;
      avsRead <= ~w;
      avsWritedata <= {24'h0, v};
      avsByteenable <= be;
      do @(posedge clk); while (avsWaitrequest !== 1'b0 && ++n < 20);
      if (avsWaitrequest !== 1'b0) begin
         fail_count++;
         finish_test;
      end
      rdv = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask : acc
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      acc(1'b1, a, v, 4'hF);
   endtask : wr
   task automatic chk(input logic [4:0] a, input logic [31:0] e);
      acc(1'b0, a, 8'h00, 4'hF);
      cmp(rdv, e);
   endtask : chk
   task automatic finish_test;
      $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      #100000;
      fail_count++;
      finish_test;
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      cmp({24'h0, padsOe}, 32'h0);
      for (int i = 0; i < 8; i++)
         if (i != 3 && i != 6) chk(5'(i * 4), 32'h0);
      chk(OFS_P2_DATA, 32'hFA);
      chk(OFS_P5_DATA, 32'h5F);
      wr(OFS_P5_FUNC, 8'hFF);
      chk(OFS_P5_FUNC, 32'h20);
      wr(OFS_P1_FUNC, 8'hFF);
      chk(OFS_P1_FUNC, 32'h92);
      wr(OFS_P1_DIR, 8'h90);
      wr(OFS_P5_DIR, 8'hE0);
      @(posedge clk);
      serialTxData <= 1'b1;
      @(negedge clk);
      cmp({16'h0, padsOe, padsOut}, 32'h2620);
      cmp({27'h0, ext_interrupt_three, timer_trigger_input, ext_interrupt_zero, wakeup_input_five,
         converter_trigger_input}, 32'h0);
      wr(OFS_P1_FUNC, 8'h00);
      wr(OFS_P5_FUNC, 8'h00);
      @(negedge clk);
      cmp({24'h0, padsOe}, 32'hC7);
      cmp({27'h0, ext_interrupt_three, timer_trigger_input, ext_interrupt_zero, wakeup_input_five,
         converter_trigger_input}, 32'h1F);
      wr(OFS_P2_DATA, 8'hFD);
      wr(OFS_P2_DIR, 8'hFC);
      acc(1'b1, OFS_P2_DATA, 8'h00, 4'h0);
      chk(OFS_P2_DATA, 32'hFE);
      wr(OFS_P2_DIR, 8'h07);
      chk(OFS_P2_DATA, 32'hFD);
      chk(OFS_P2_DIR, 32'h0);
      cmp({26'h0, padsOe[5:3], padsOut[5:3]}, 32'h3D);
      wr(OFS_P5_DATA, 8'hBF);
      wr(OFS_P5_DIR, 8'h9F);
      chk(OFS_P5_DATA, 32'hDF);
      wr(OFS_P5_DIR, 8'hE0);
      chk(OFS_P5_DATA, 32'hBF);
      cmp({26'h0, padsOe[2:0], padsOut[2:0]}, 32'h3D);
      @(posedge clk);
      rx_enable_bit <= 1'b1;
      board[4:3] <= 2'b01;
      @(negedge clk);
      cmp({30'h0, padsOe[4], serialRxData}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {clock_source_hi_bit, clock_source_lo_bit, serialSyncMode} <= 3'(i);
         serialClockOut <= i[1];
         @(negedge clk);
         cmp({29'h0, padsOe[3], padsOe[3] & padsOut[3], serialClockIn},
            {29'h0, !i[2], !i[2] && (i[1:0] == 2'b00 || i[1]), i[2]});
      end
      @(posedge clk);
      {rx_enable_bit, clock_source_hi_bit, clock_source_lo_bit, serialSyncMode} <= 4'h0;
      i2c_enable_bit <= 1'b1;
      board[2:1] <= 2'b11;
      for (int j = 0; j < 4; j++) begin
         @(posedge clk);
         {i2cSclPullLow, i2cSdaPullLow} <= 2'(j);
         @(negedge clk);
         cmp({26'h0, padsOe[2:1], padsOut[2:1], i2cSclIn, i2cSdaIn},
            {26'h0, 2'(j), 2'b00, ~2'(j)});
      end
      @(posedge clk);
      i2c_enable_bit <= 1'b0;
      @(negedge clk);
      cmp({29'h0, padsOe[2:0]}, 32'h7);
      finish_test;
   end
endmodule : testbench
`default_nettype wire
